/* design/spict_pkg.sv */
package spict_pkg;

  // Core register addresses and reset values
  localparam logic [7:0] RATE_ADDR = 8'ha2;
  localparam logic [7:0] DATA_ADDR = 8'ha3;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Slave select pin handling
  localparam logic [1:0] SEL_UNUSED = 2'h0;
  localparam logic [1:0] SEL_INPUT = 2'h1;
  localparam int SEL_OUT_BIT = 1;

  // Transfer shape
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] LAST_EDGE = 5'h10;
  localparam logic [4:0] MASTER_END_PHASE0 = 5'h10;
  localparam logic [4:0] MASTER_END_PHASE1 = 5'h11;
  localparam logic [4:0] FIRST_LATE_SHIFT = 5'h03;

  // Timing in core clock periods
  localparam int SYNC_LAT = 3;
  localparam int SLH_MIN_PERIODS = 6;
  localparam int SLH_MAX_PERIODS = 8;
  localparam int SLH_TARGET = (SLH_MIN_PERIODS + SLH_MAX_PERIODS) / 2;
  localparam logic [2:0] SLH_COUNT = 3'(SLH_TARGET - SYNC_LAT - 2);

  // Edge that moves the clock away from its idle level
  function automatic logic spict_leading(input logic prev, input logic cur, input logic pol);
    spict_leading = (prev == pol) && (cur != pol);
  endfunction

  // Edge that returns the clock to its idle level
  function automatic logic spict_trailing(input logic prev, input logic cur, input logic pol);
    spict_trailing = (prev != pol) && (cur == pol);
  endfunction

endpackage

/* design/spict_sync.sv */
`timescale 1ns/100ps
module spict_sync
  import spict_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pin side
  input wire logic pinIn,
  // Filtered level
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic held;
  } spict_sync_state_t;

  spict_sync_state_t st_q;
  spict_sync_state_t st_d;

  // First stage is only read by the second; a change counts once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.held = st_q.s3;
    end
  end

  // Agreement is used directly so the filtered level lags the pin by three edges only
  assign level = (st_q.s2 == st_q.s3) ? st_q.s3 : st_q.held;

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* design/spict_rate_div.sv */
`timescale 1ns/100ps
module spict_rate_div
  import spict_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [7:0] divisor,
  // One-cycle pulse per serial clock half period
  output logic halfTick
);

  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } spict_div_state_t;

  spict_div_state_t st_q;
  spict_div_state_t st_d;

  // Half period is divisor plus one core clocks, never shorter than one
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.count = 8'h00;
    end else if (st_q.count == divisor) begin
      st_d.count = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.count = st_q.count + 8'h01;
    end
  end

  assign halfTick = st_q.tick;

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* design/spict_core.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Master serial clock is core clock over twice the sum of divider and one.
// - Data write loads transmit buffer; in master role it starts a transfer.
// - Data read returns the receive buffer, never the transmit buffer.
// - Polarity select one inverts idle and active clock levels, timing unchanged.
// - Master clock high and low phases each last at least one core clock.
// - Slave drives valid MISO within four core clocks of select falling.
// - Slave releases MISO within four core clocks of select rising.
// - Slave updates MISO within four core clocks of each shifting edge.
// - Slave with phase one changes MISO six to eight clocks after final edge.
// - Transfer completion sets done flag; software clears; raises interrupt when enabled.
// - Data write during a transfer sets collision flag, and interrupt when enabled; software clears.
// - Master samples MISO at the bit-ending edge; slave samples MOSI mid-bit.
// - Select mode 00 unused, 01 input, 1x output following mode low bit.
module spict_core
  import spict_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Port configuration
  input wire logic spiEnable,
  input wire logic masterMode,
  input wire logic clockPolaritySel,
  input wire logic clockPhaseSel,
  input wire logic [1:0] selectPinMode,
  input wire logic irqEnable,
  // Flags and interrupt
  input wire logic clrTransferDone,
  input wire logic clrWriteCollision,
  output logic transferDoneFlag,
  output logic writeCollisionFlag,
  output logic portIrq,
  // Serial clock pin
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // Master out slave in pin
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // Master in slave out pin
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // Slave select pin
  input wire logic slaveSelectInN,
  output logic slaveSelectOutN,
  output logic slaveSelectOe
);

  typedef enum logic [0:0] {
    MS_IDLE,
    MS_RUN
  } spict_mstate_t;

  typedef struct packed {
    spict_mstate_t mState;
    logic [4:0] phase;
    logic [7:0] rate;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic [7:0] shift;
    logic [3:0] bits;
    logic sckPrev;
    logic selPrev;
    logic slhArm;
    logic [2:0] slhCnt;
    logic doneFlag;
    logic wcolFlag;
    logic irq;
    logic [7:0] rdData;
    logic sckOut;
    logic sckOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
    logic ssnOut;
    logic ssnOe;
  } spict_core_state_t;

  spict_core_state_t st_q;
  spict_core_state_t st_d;

  logic sckS;
  logic mosiS;
  logic misoS;
  logic ssnS;
  logic halfTick;

  // Pin inputs cross into the core clock domain
  spict_sync #(.RESET_LEVEL(1'b0)) u_sync_sck (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(sckIn),
    .level(sckS)
  );

  spict_sync #(.RESET_LEVEL(1'b0)) u_sync_mosi (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(mosiIn),
    .level(mosiS)
  );

  spict_sync #(.RESET_LEVEL(1'b0)) u_sync_miso (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(misoIn),
    .level(misoS)
  );

  // Select idles high so the port is not selected out of reset
  spict_sync #(.RESET_LEVEL(1'b1)) u_sync_ssn (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(slaveSelectInN),
    .level(ssnS)
  );

  // Half period enable for the master serial clock
  spict_rate_div u_rate_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(st_q.mState == MS_RUN),
    .divisor(st_q.rate),
    .halfTick(halfTick)
  );

  logic masterOn;
  logic slaveOn;
  logic selected;
  logic selStart;
  logic leadEdge;
  logic trailEdge;
  logic sampleEdge;
  logic shiftEdge;
  logic slaveBusy;
  logic dataWrite;
  logic [4:0] nextPhase;
  logic masterShift;
  logic masterDrive;
  logic [4:0] masterEnd;

  // Role decode and slave edge detection on the filtered serial clock
  always_comb begin
    masterOn = spiEnable && masterMode;
    selected = (selectPinMode == SEL_INPUT) ? !ssnS : 1'b1;
    slaveOn = spiEnable && !masterMode && selected;
    selStart = slaveOn && !st_q.selPrev;
    leadEdge = spict_leading(st_q.sckPrev, sckS, clockPolaritySel);
    trailEdge = spict_trailing(st_q.sckPrev, sckS, clockPolaritySel);
    sampleEdge = clockPhaseSel ? trailEdge : leadEdge;
    shiftEdge = clockPhaseSel ? leadEdge : trailEdge;
    slaveBusy = slaveOn && (st_q.bits != 4'h0);
    dataWrite = sfrWrEn && (sfrAddr == DATA_ADDR);
    nextPhase = st_q.phase + 5'h01;
    masterEnd = clockPhaseSel ? MASTER_END_PHASE1 : MASTER_END_PHASE0;
    // Phase zero takes MISO at the bit-ending edge; phase one from the third edge on
    if (clockPhaseSel) begin
      masterShift = nextPhase[0] && (nextPhase >= FIRST_LATE_SHIFT);
      masterDrive = nextPhase[0];
    end else begin
      masterShift = !nextPhase[0];
      masterDrive = !nextPhase[0];
    end
  end

  // Next state of the whole port
  always_comb begin
    st_d = st_q;
    st_d.sckPrev = sckS;
    st_d.selPrev = slaveOn;

    // Software clears go first so a set from either engine in the same cycle wins
    if (clrTransferDone) begin
      st_d.doneFlag = 1'b0;
    end
    if (clrWriteCollision) begin
      st_d.wcolFlag = 1'b0;
    end

    // Register writes; a busy port refuses the data byte and flags it
    if (sfrWrEn && (sfrAddr == RATE_ADDR)) begin
      st_d.rate = sfrWrData;
    end
    if (dataWrite) begin
      if ((st_q.mState == MS_RUN) || slaveBusy) begin
        st_d.wcolFlag = 1'b1;
      end else begin
        st_d.txBuf = sfrWrData;
      end
    end

    // Master transfer engine
    case (st_q.mState)
      MS_IDLE: begin
        st_d.phase = 5'h00;
        st_d.sckOut = clockPolaritySel;
        if (masterOn && dataWrite) begin
          st_d.shift = sfrWrData;
          st_d.mosiOut = sfrWrData[7];
          st_d.mState = MS_RUN;
        end
      end
      MS_RUN: begin
        if (!masterOn) begin
          st_d.mState = MS_IDLE;
        end else if (halfTick) begin
          st_d.phase = nextPhase;
          if (nextPhase <= LAST_EDGE) begin
            st_d.sckOut = !st_q.sckOut;
          end
          if (masterShift) begin
            st_d.shift = {st_q.shift[6:0], misoS};
          end
          if (masterDrive) begin
            st_d.mosiOut = st_d.shift[7];
          end
          if (nextPhase == masterEnd) begin
            st_d.rxBuf = st_d.shift;
            st_d.doneFlag = 1'b1;
            st_d.mState = MS_IDLE;
          end
        end
      end
      default: begin
        st_d.mState = MS_IDLE;
      end
    endcase

    // Slave transfer engine, timed from filtered pin edges
    if (!slaveOn) begin
      st_d.bits = 4'h0;
      st_d.slhArm = 1'b0;
      st_d.slhCnt = 3'h0;
    end else if (selStart) begin
      st_d.shift = st_d.txBuf;
      st_d.misoOut = st_d.txBuf[7];
      st_d.bits = 4'h0;
    end else begin
      if (shiftEdge) begin
        st_d.misoOut = st_q.shift[7];
      end
      if (sampleEdge) begin
        st_d.shift = {st_q.shift[6:0], mosiS};
        st_d.bits = st_q.bits + 4'h1;
        if (st_q.bits == LAST_BIT) begin
          st_d.rxBuf = {st_q.shift[6:0], mosiS};
          st_d.doneFlag = 1'b1;
          st_d.shift = st_d.txBuf;
          st_d.bits = 4'h0;
          st_d.slhArm = clockPhaseSel;
          st_d.slhCnt = 3'h0;
        end
      end
      // Phase one: present the next byte a fixed delay after the final edge
      if (st_q.slhArm) begin
        st_d.slhCnt = st_q.slhCnt + 3'h1;
        if (st_q.slhCnt == SLH_COUNT) begin
          st_d.misoOut = st_q.shift[7];
          st_d.slhArm = 1'b0;
        end
      end
    end

    // Pin drivers; MISO is released as soon as the port is deselected
    st_d.sckOe = masterOn;
    st_d.mosiOe = masterOn;
    st_d.misoOe = slaveOn;
    st_d.ssnOe = selectPinMode[SEL_OUT_BIT];
    st_d.ssnOut = selectPinMode[SEL_OUT_BIT] ? selectPinMode[0] : 1'b1;
    if (!masterOn && (st_q.mState == MS_IDLE)) begin
      st_d.sckOut = clockPolaritySel;
    end

    // Interrupt follows the flags as they will stand next cycle
    st_d.irq = irqEnable && (st_d.doneFlag || st_d.wcolFlag);

    // Read data answers one cycle after the strobe
    st_d.rdData = READ_ZERO;
    if (sfrRdEn) begin
      if (sfrAddr == DATA_ADDR) begin
        st_d.rdData = st_q.rxBuf;
      end else if (sfrAddr == RATE_ADDR) begin
        st_d.rdData = st_q.rate;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.mState <= MS_IDLE;
      st_q.rate <= RATE_RESET;
      st_q.txBuf <= DATA_RESET;
      st_q.rxBuf <= DATA_RESET;
      st_q.ssnOut <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign sfrRdData = st_q.rdData;
  assign transferDoneFlag = st_q.doneFlag;
  assign writeCollisionFlag = st_q.wcolFlag;
  assign portIrq = st_q.irq;
  assign sckOut = st_q.sckOut;
  assign sckOe = st_q.sckOe;
  assign mosiOut = st_q.mosiOut;
  assign mosiOe = st_q.mosiOe;
  assign misoOut = st_q.misoOut;
  assign misoOe = st_q.misoOe;
  assign slaveSelectOutN = st_q.ssnOut;
  assign slaveSelectOe = st_q.ssnOe;

endmodule

/* dv/spict_core_asserts.sv */
`timescale 1ns/100ps
module spict_core_asserts
  import spict_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port and configuration
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  input wire logic spiEnable,
  input wire logic masterMode,
  input wire logic clockPolaritySel,
  input wire logic [1:0] selectPinMode,
  input wire logic irqEnable,
  input wire logic clrTransferDone,
  // Flags and pins
  input wire logic transferDoneFlag,
  input wire logic writeCollisionFlag,
  input wire logic portIrq,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic misoOe,
  input wire logic slaveSelectInN,
  input wire logic slaveSelectOutN,
  input wire logic slaveSelectOe
);
  logic [7:0] rate_q;
  logic [8:0] gap_q;
  logic [3:0] edges_q;
  logic busy_q;
  logic slvSel;
  logic mStart;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign slvSel = spiEnable && !masterMode && selectPinMode == SEL_INPUT;
  // An idle master data write opens a transfer; polarity moves outside one are not counted
  assign mStart = sfrWrEn && sfrAddr == DATA_ADDR && spiEnable && masterMode && !busy_q
    && gap_q > {1'b0, rate_q};
  // Rate, cycles since the last transfer toggle, toggles so far; sixteenth toggle ends it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rate_q <= 8'h00;
      gap_q <= 9'h1ff;
      edges_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      if (sfrWrEn && sfrAddr == RATE_ADDR)
        rate_q <= sfrWrData;
      if (busy_q && $changed(sckOut)) begin
        gap_q <= 9'h000;
        edges_q <= edges_q + 4'h1;
        if (edges_q == 4'hf)
          busy_q <= 1'b0;
      end else if (gap_q != 9'h1ff)
        gap_q <= gap_q + 9'h001;
      if (mStart) begin
        edges_q <= 4'h0;
        busy_q <= 1'b1;
      end
    end
  end
  property p_period;
    busy_q && sckOe && $changed(sckOut) && edges_q != 4'h0 |-> gap_q == {1'b0, rate_q};
  endproperty
  a_period: assert property (p_period) else $error("bad half period");
  property p_rd_idle;
    !sfrRdEn |=> sfrRdData == READ_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_idle_lvl;
    $rose(transferDoneFlag) && masterMode |-> sckOut == clockPolaritySel;
  endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("clock not at idle level");
  property p_done_sticky;
    transferDoneFlag && !clrTransferDone |=> transferDoneFlag;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");
  property p_irq;
    portIrq == ($past(irqEnable) && (transferDoneFlag || writeCollisionFlag));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_coll;
    sfrWrEn && sfrAddr == DATA_ADDR && busy_q && edges_q < 4'hf |=> writeCollisionFlag;
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged");
  property p_miso_on;
    $fell(slaveSelectInN) && slvSel |-> ##[0:4] misoOe;
  endproperty
  a_miso_on: assert property (p_miso_on) else $error("miso not driven");
  property p_miso_off;
    $rose(slaveSelectInN) && slvSel |-> ##[0:4] !misoOe;
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso not released");
  property p_sel_out;
    selectPinMode[SEL_OUT_BIT] && $stable(selectPinMode)
      |-> ##[0:1] (slaveSelectOe && slaveSelectOutN == selectPinMode[0]);
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("select output wrong");
endmodule
bind spict_core spict_core_asserts i_spict_core_asserts (.ref_clk, .reset, .sfrAddr,
  .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData, .spiEnable, .masterMode, .clockPolaritySel,
  .selectPinMode, .irqEnable, .clrTransferDone, .transferDoneFlag, .writeCollisionFlag,
  .portIrq, .sckOut, .sckOe, .misoOe, .slaveSelectInN, .slaveSelectOutN, .slaveSelectOe);

/* dv/spict_peer.sv */
`timescale 1ns/100ps
module spict_peer (
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  // Mode and preload
  input wire logic pol,
  input wire logic pha,
  input wire logic load,
  input wire logic [7:0] txByte,
  // Answer
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] shiftReg;
  logic outBit;
  // Deselected, the line shows the inverse so stale data cannot pass
  assign miso = selN ? ~outBit : outBit;
  // Phase one shows a wrong first bit until its leading edge
  always @(posedge load) begin
    shiftReg = txByte;
    outBit = txByte[7] ^ pha;
  end
  // Sample on one edge and shift on the other, MSB first
  always @(sck) begin
    if ((sck != pol) != pha)
      rxByte = {rxByte[6:0], mosi};
    else if (pha) begin
      outBit = shiftReg[7];
      shiftReg = shiftReg << 1;
    end else begin
      shiftReg = shiftReg << 1;
      outBit = shiftReg[7];
    end
  end
endmodule

/* dv/spi_clock_data_timing_bench.sv */
`timescale 1ns/100ps
module spi_clock_data_timing_bench
  import spict_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, spiEnable = 1'b1;
  logic masterMode = 1'b1, clockPolaritySel = 1'b0, clockPhaseSel = 1'b0, irqEnable = 1'b0;
  logic clrTransferDone = 1'b0, clrWriteCollision = 1'b0, sckIn = 1'b0, mosiIn = 1'b0;
  logic slaveSelectInN = 1'b1, peerLoad = 1'b0, misoIn;
  logic transferDoneFlag, writeCollisionFlag, portIrq, sckOut, sckOe, mosiOut, mosiOe;
  logic misoOut, misoOe, slaveSelectOutN, slaveSelectOe;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, peerTx = 8'h00, sfrRdData, peerRx, d, tx, rt;
  logic [1:0] selectPinMode = 2'h2;
  logic [31:0] seed = 32'hff04;
  logic [7:0] expQ[$];
  int fails = 0;
  int cmp_count = 0;
  int n;
  spict_core i_spict_core (.ref_clk, .reset, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData,
    .sfrRdData, .spiEnable, .masterMode, .clockPolaritySel, .clockPhaseSel, .selectPinMode,
    .irqEnable, .clrTransferDone, .clrWriteCollision, .transferDoneFlag, .writeCollisionFlag,
    .portIrq, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe,
    .slaveSelectInN, .slaveSelectOutN, .slaveSelectOe);
  spict_peer i_spict_peer (.sck(sckOut), .mosi(mosiOut), .selN(slaveSelectOutN),
    .pol(clockPolaritySel), .pha(clockPhaseSel), .load(peerLoad), .txByte(peerTx),
    .miso(misoIn), .rxByte(peerRx));
  // Core clock, 40 ns period
  initial forever #20 ref_clk = ~ref_clk;
  // Pseudo random source
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (a !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWrEn <= 1'b1;
    @(posedge ref_clk);
    sfrWrEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Answer stands one cycle, so it is looked at mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge ref_clk);
    sfrRdEn <= 1'b0;
    @(negedge ref_clk);
    chk(sfrRdData, e);
    @(posedge ref_clk);
  endtask
  task automatic clr;
    clrTransferDone <= 1'b1;
    clrWriteCollision <= 1'b1;
    @(posedge ref_clk);
    clrTransferDone <= 1'b0;
    clrWriteCollision <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic waitDone;
    for (n = 0; n < 20000 && transferDoneFlag !== 1'b1; n++)
      @(posedge ref_clk);
    if (n == 20000) begin
      fails++;
      $display("[FAIL] %0t no completion", $time);
      end_of_test;
    end
  endtask
  // Bench acts as external master in the current mode; slow phases keep the filter happy
  task automatic slv(input logic [7:0] mo, input logic [7:0] txb);
    slaveSelectInN <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= mo[i];
      if (clockPhaseSel)
        sckIn <= ~clockPolaritySel;
      repeat (6) @(posedge ref_clk);
      chk({7'h00, misoOut}, {7'h00, txb[i]});
      sckIn <= ~sckIn;
      repeat (6) @(posedge ref_clk);
      if (!clockPhaseSel)
        sckIn <= clockPolaritySel;
    end
    // Phase one: old bit still shown six cycles after the final edge, next byte by nine
    if (clockPhaseSel) begin
      chk({7'h00, misoOut}, {7'h00, txb[0]});
      repeat (3) @(posedge ref_clk);
      chk({7'h00, misoOut}, {7'h00, txb[7]});
    end
    repeat (3) @(posedge ref_clk);
    slaveSelectInN <= 1'b1;
    mosiIn <= ~mo[0];
    repeat (6) @(posedge ref_clk);
  endtask
  task end_of_test;
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence: registers, master in all four modes, then slave role
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(RATE_ADDR, RATE_RESET);
    rd(DATA_ADDR, DATA_RESET);
    wr(8'h55, 8'h3c);
    rd(8'h55, READ_ZERO);
    for (int k = 0; k < 5; k++) begin
      seed = nextRand(seed);
      rt = (k == 3) ? 8'hff : (k == 4) ? 8'h00 : 8'h03 + {5'h00, seed[2:0]};
      {clockPolaritySel, clockPhaseSel} <= 2'(k);
      selectPinMode <= (k == 4) ? 2'h3 : 2'h2;
      irqEnable <= k[0];
      wr(RATE_ADDR, rt);
      rd(RATE_ADDR, rt);
      seed = nextRand(seed);
      tx = seed[7:0];
      expQ.push_back(seed[15:8]);
      peerTx <= seed[15:8];
      peerLoad <= 1'b1;
      @(posedge ref_clk);
      peerLoad <= 1'b0;
      wr(DATA_ADDR, tx);
      if (k == 1) begin
        repeat (20) @(posedge ref_clk);
        wr(DATA_ADDR, ~tx);
      end
      waitDone;
      chk({6'h00, sckOe, mosiOe}, 8'h03);
      chk(peerRx, tx);
      chk({7'h00, writeCollisionFlag}, {7'h00, k == 1});
      d = expQ.pop_front();
      if (rt > 8'h02)
        rd(DATA_ADDR, d);
      clr;
      chk({6'h00, transferDoneFlag, writeCollisionFlag}, 8'h00);
    end
    masterMode <= 1'b0;
    selectPinMode <= SEL_INPUT;
    // Slave role in mode 0, then with polarity and phase both set; clock idles first
    for (int m = 0; m < 2; m++) begin
      {clockPolaritySel, clockPhaseSel} <= {m[0], m[0]};
      sckIn <= m[0];
      seed = nextRand(seed);
      tx = {~seed[0], seed[6:0]};
      wr(DATA_ADDR, tx);
      slv(seed[15:8], tx);
      waitDone;
      rd(DATA_ADDR, seed[15:8]);
      clr;
    end
    end_of_test;
  end
endmodule
